// ---- verilog/sbp_sram_port.sv ----
// pipelined burst sram: pin-level command path, array and status regs
// assumes the controller shares clk_i; oe and sleep pins are async
`timescale 1ns/10ps
`default_nettype none

// Operation
// - pin clock enable high freezes the edge
// - four 9-bit lanes, each own write enable
// - lane enables ignored on read cycles
// - enabled lanes written two cycles after command
// - any chip enable off with load deselects
// - data bus floats two cycles after deselect
// - high chip enable acts like low ones
// - everything timed on rising clock edge
// - data in and out paths are registered
// - order pin high interleaved, low linear
// - output enable high floats data pins
// - sleep freezes logic, array contents kept
// - load data moves two cycles after command
// - advance ignores address, steps burst counter
// - a burst carries at most four words
// - deselect with load ends burst in progress
module sbp_sram_port
  import sbp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // memory pins
  input wire logic clk_enable_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic read_not_write_i,
  input wire logic advance_or_load_i,
  input wire logic chip_select1_n_i,
  input wire logic chip_select2_n_i,
  input wire logic chip_select_hi_i,
  input wire logic [LANES-1:0] byte_write_n_i,
  input wire logic linear_order_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic [DATA_W-1:0] data_pins_i,
  input wire logic [LANES-1:0] parity_pins_i,
  output logic [DATA_W-1:0] data_pins_o,
  output logic [LANES-1:0] parity_pins_o,
  output logic data_oe_o
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [WORD_W-1:0] mem [0:DEPTH-1];
  logic oen_s;
  logic sleep_s;
  logic act;
  logic sel;
  logic load;
  logic desel;
  logic adv_go;
  logic burst_go;
  logic burst_run;
  logic [1:0] next_lo;
  sbp_cmd_t c0;
  sbp_cmd_t p1_r;
  sbp_cmd_t p2_r;
  sbp_cmd_t wpend_r;
  logic [ADDR_W-1:0] base_r;
  logic burst_wr_r;
  logic [WORD_W-1:0] pin_word;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] din_r;
  logic [WORD_W-1:0] dout_r;
  logic p2_live;
  logic rd_nxt;
  logic rd_phase_r;
  logic oe_r;
  logic wblk_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic wb_req;
  logic [31:0] stat_word;

  // merge enabled lanes of nw over old; parity bit rides with its lane
  function automatic logic [WORD_W-1:0] lane_merge(
    input logic [WORD_W-1:0] old,
    input logic [WORD_W-1:0] nw,
    input logic [LANES-1:0] be_n
  );
    logic [WORD_W-1:0] w;
    w = old;
    for (int k = 0; k < LANES; k++) begin
      if (!be_n[k]) begin
        w[k*LANE_D +: LANE_D] = nw[k*LANE_D +: LANE_D];
        w[DATA_W+k] = nw[DATA_W+k];
      end
    end
    return w;
  endfunction

  // ------------------------------------------------------------
  // asynchronous pins
  // ------------------------------------------------------------
  // oe and sleep are async: two flops before use, so they act
  // two cycles late; outputs start disabled
  sbp_sync2 #(
    .W(2),
    .RST_VAL(2'h1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({sleep_request_i, output_enable_n_i}),
    .q_o({sleep_s, oen_s})
  );

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  // an edge counts only with pin enable low, ce_i high, awake
  assign act = ce_i && !clk_enable_n_i && !sleep_s;
  // all three enables must be asserted to select
  assign sel = !chip_select1_n_i && !chip_select2_n_i
               && chip_select_hi_i;
  assign load = act && !advance_or_load_i && sel;
  assign desel = act && !advance_or_load_i && !sel;
  // advance never looks at addr_i
  assign adv_go = act && advance_or_load_i && burst_go;
  assign pin_word = {parity_pins_i, data_pins_i};

  // new command for this edge
  always_comb begin
    c0 = '0;
    if (load) begin
      c0.vld = 1'b1;
      c0.wr = !read_not_write_i;
      c0.addr = addr_i;
      // lane enables only matter on writes
      c0.be_n = read_not_write_i ? BE_NONE : byte_write_n_i;
    end else if (adv_go) begin
      c0.vld = 1'b1;
      c0.wr = burst_wr_r;
      c0.addr = {base_r[ADDR_W-1:2], next_lo};
      c0.be_n = burst_wr_r ? byte_write_n_i : BE_NONE;
    end
  end

  // ------------------------------------------------------------
  // burst counter
  // ------------------------------------------------------------
  sbp_burst_ctr u_burst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(act),
    .load_i(load),
    .term_i(desel),
    .adv_i(advance_or_load_i),
    .start_i(addr_i[1:0]),
    .interleave_i(linear_order_n_i),
    .go_o(burst_go),
    .run_o(burst_run),
    .next_lo_o(next_lo)
  );

  // ------------------------------------------------------------
  // two-stage command pipeline
  // ------------------------------------------------------------
  // frozen edges hold every stage, so data timing stays intact
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1_r <= '0;
      p2_r <= '0;
      base_r <= '0;
      burst_wr_r <= 1'b0;
    end else if (act) begin
      p1_r <= c0;
      p2_r <= p1_r;
      if (load) begin
        base_r <= addr_i;
        burst_wr_r <= !read_not_write_i;
      end
    end
  end

  // ------------------------------------------------------------
  // write path
  // ------------------------------------------------------------
  // write data sits on the pins during the second cycle
  assign p2_live = p2_r.vld && p2_r.wr && !wblk_r;

  // input register, then one pending slot into the array
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_r <= '0;
      wpend_r <= '0;
    end else if (act) begin
      wpend_r <= '0;
      if (p2_live) begin
        din_r <= pin_word;
        wpend_r <= p2_r;
      end
    end
  end

  // array itself is never reset; contents survive sleep
  always_ff @(posedge clk_i) begin
    if (!rst_i && act && wpend_r.vld) begin
      mem[wpend_r.addr] <= lane_merge(mem[wpend_r.addr], din_r,
                                      wpend_r.be_n);
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // forward the pending and the incoming write, so a read right
  // behind a write to the same word sees the new lanes
  always_comb begin
    rd_word = mem[p1_r.addr];
    if (wpend_r.vld && wpend_r.addr == p1_r.addr) begin
      rd_word = lane_merge(rd_word, din_r, wpend_r.be_n);
    end
    if (p2_live && p2_r.addr == p1_r.addr) begin
      rd_word = lane_merge(rd_word, pin_word, p2_r.be_n);
    end
  end

  assign rd_nxt = act ? (p1_r.vld && !p1_r.wr) : rd_phase_r;

  // output register loads at the edge after the command edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_r <= '0;
      rd_phase_r <= 1'b0;
    end else if (act) begin
      rd_phase_r <= rd_nxt;
      if (p1_r.vld && !p1_r.wr) begin
        dout_r <= rd_word;
      end
    end
  end

  // drive enable follows oe and sleep on every edge with ce_i high, even frozen ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_r <= 1'b0;
    end else if (ce_i) begin
      oe_r <= rd_nxt && !oen_s && !sleep_s;
    end
  end

  assign data_pins_o = dout_r[DATA_W-1:0];
  assign parity_pins_o = dout_r[WORD_W-1:DATA_W];
  assign data_oe_o = oe_r;

  // ------------------------------------------------------------
  // wishbone registers
  // ------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign stat_word = {27'h0, oe_r, wpend_r.vld, rd_phase_r,
                      burst_run, sleep_s};

  // single-cycle ack; unmapped words ack and read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= wb_req;
    end
  end

  // write block stops array updates, handy for scrubbing tests
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wblk_r <= 1'b0;
    end else if (ce_i && wb_req && wb_we_i && wb_sel_i[0]
                 && wb_adr_i[3:2] == REG_CTRL) begin
      wblk_r <= wb_dat_i[CTRL_WBLK];
    end
  end

  // read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (ce_i && wb_req) begin
      unique case (wb_adr_i[3:2])
        REG_CTRL: dat_r <= {31'h0, wblk_r};
        REG_STAT: dat_r <= stat_word;
        default: dat_r <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_read_load;
    act && load && read_not_write_i ##1 act;
  endsequence
  sequence s_lin_pair;
    act && load && !linear_order_n_i ##1 adv_go;
  endsequence
  sequence s_il_pair;
    act && load && linear_order_n_i ##1 adv_go;
  endsequence
  a_freeze_hold: assert property (
    !act |=> $stable(p1_r) && $stable(p2_r) && $stable(dout_r))
    else $error("state moved on a frozen edge");
  a_pend_hold: assert property (
    !act |=> $stable(wpend_r) && $stable(din_r) && $stable(base_r))
    else $error("pending write moved on a frozen edge");
  a_read_time: assert property (
    s_read_load |=> rd_phase_r && dout_r == $past(rd_word))
    else $error("read data not loaded one edge after command");
  a_write_time: assert property (
    act && c0.vld && c0.wr && !wblk_r ##1 act ##1 act
      |=> wpend_r.vld && wpend_r.be_n == $past(p2_r.be_n))
    else $error("write not captured two cycles after command");
  a_read_be_off: assert property (
    act && load && read_not_write_i |=> p1_r.be_n == BE_NONE)
    else $error("lane enables leaked into a read");
  a_desel_idle: assert property (
    desel |=> !p1_r.vld)
    else $error("deselect launched a command");
  a_desel_float: assert property (
    desel ##1 act |=> !data_oe_o)
    else $error("bus still driven after deselect");
  a_desel_end: assert property (
    desel |=> !burst_run)
    else $error("burst survived deselect");
  a_lin_order: assert property (
    s_lin_pair |=> p1_r.addr[1:0] == $past(addr_i[1:0], 2) + BEAT_ONE)
    else $error("linear beat address wrong");
  a_il_order: assert property (
    s_il_pair |=> p1_r.addr[1:0] == ($past(addr_i[1:0], 2) ^ BEAT_ONE))
    else $error("interleaved beat address wrong");
  a_adv_base: assert property (
    adv_go |=> p1_r.addr[ADDR_W-1:2] == $past(base_r[ADDR_W-1:2]))
    else $error("advance used the external address");
  a_oe_gate: assert property (
    ce_i && oen_s |=> !data_oe_o)
    else $error("pins driven with output enable high");
  // ce_i low holds oe_r, so only an enabled edge must drop the drive
  a_sleep_hold: assert property (
    ce_i && sleep_s |=> $stable(p1_r) && !data_oe_o)
    else $error("activity during sleep");
endmodule // sbp_sram_port
`default_nettype wire

// ---- verilog/sbp_pkg.sv ----
// constants, carriers and helpers for the burst sram port
// assumes a single 25 MHz clock domain and no other packages
`default_nettype none
package sbp_pkg;

  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int LANES = 4;
  localparam int LANE_D = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 36;
  localparam int DEPTH = 1 << ADDR_W;

  // ------------------------------------------------------------
  // burst and lane constants
  // ------------------------------------------------------------
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [1:0] BEAT_ONE = 2'h1;
  localparam logic [1:0] BEAT_ZERO = 2'h0;
  localparam logic [3:0] BE_NONE = 4'hf;

  // ------------------------------------------------------------
  // wishbone register map, word index on adr[3:2]
  // ------------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam int CTRL_WBLK = 0;
  localparam int ST_SLEEP = 0;
  localparam int ST_BURST = 1;
  localparam int ST_RDPH = 2;
  localparam int ST_WPEND = 3;
  localparam int ST_OE = 4;

  // one pipeline slot of the command path
  typedef struct packed {
    logic vld;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] be_n;
  } sbp_cmd_t;

  typedef enum logic {
    BURST_IDLE = 1'b0,
    BURST_RUN = 1'b1
  } sbp_burst_t;

  // low address bits of a beat: xor for interleaved, add for linear
  function automatic logic [1:0] sbp_beat_addr(input logic [1:0] start,
                                               input logic [1:0] cnt,
                                               input logic il);
    logic [1:0] s;
    s = start + cnt;
    return il ? (start ^ cnt) : s;
  endfunction

endpackage
`default_nettype wire

// ---- verilog/sbp_sync2.sv ----
// two-flop synchroniser for asynchronous pin levels
// assumes clk_i is the port clock and ce_i freezes it like all state
`timescale 1ns/10ps
`default_nettype none
module sbp_sync2 #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_r <= RST_VAL;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule // sbp_sync2
`default_nettype wire

// ---- verilog/sbp_burst_ctr.sv ----
// four-beat burst counter, linear or interleaved order
// assumes en_i already folds in clock enable, pin enable and sleep
`timescale 1ns/10ps
`default_nettype none
module sbp_burst_ctr
  import sbp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic load_i,
  input wire logic term_i,
  input wire logic adv_i,
  input wire logic [1:0] start_i,
  input wire logic interleave_i,
  output logic go_o,
  output logic run_o,
  output logic [1:0] next_lo_o
);

  sbp_burst_t state_r;
  logic [1:0] start_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  assign cnt_nxt = cnt_r + BEAT_ONE;

  // only the two lowest address bits ever move
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= BURST_IDLE;
      start_r <= BEAT_ZERO;
      cnt_r <= BEAT_ZERO;
    end else if (en_i) begin
      unique case (state_r)
        BURST_IDLE: begin
          if (load_i) begin
            state_r <= BURST_RUN;
            start_r <= start_i;
            cnt_r <= BEAT_ZERO;
          end
        end
        BURST_RUN: begin
          if (load_i) begin
            start_r <= start_i;
            cnt_r <= BEAT_ZERO;
          end else if (term_i) begin
            state_r <= BURST_IDLE;
          end else if (adv_i) begin
            if (cnt_r == LAST_BEAT) begin
              state_r <= BURST_IDLE;
            end else begin
              cnt_r <= cnt_nxt;
            end
          end
        end
      endcase
    end
  end

  assign run_o = (state_r == BURST_RUN);
  assign go_o = run_o && (cnt_r != LAST_BEAT);
  assign next_lo_o = sbp_beat_addr(start_r, cnt_nxt, interleave_i);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_burst_limit: assert property (
    en_i && run_o && cnt_r == LAST_BEAT && adv_i && !load_i |=> !run_o)
    else $error("burst ran past four beats");

  a_beat_step: assert property (
    en_i && run_o && go_o && adv_i && !load_i && !term_i
      |=> cnt_r == $past(cnt_r) + BEAT_ONE)
    else $error("burst counter did not step by one");

endmodule // sbp_burst_ctr
`default_nettype wire

// ---- tb/sbp_ctl_model.sv ----
// controller model: drives the sram pins and captures every read beat
// assumes beat() is called just after a rising clk_i edge
`timescale 1ns/10ps
`default_nettype none
module sbp_ctl_model
  import sbp_pkg::*;
(
  input wire logic clk_i,
  input wire logic [DATA_W-1:0] data_pins_i,
  input wire logic [LANES-1:0] parity_pins_i,
  input wire logic data_oe_i,
  output logic clk_enable_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic read_not_write_o,
  output logic advance_or_load_o,
  output logic [2:0] sel_o,
  output logic [LANES-1:0] byte_write_n_o,
  output logic [WORD_W-1:0] wdata_o
);
  // ----------------------------------------------------------------
  // two-stage view of {transfer, write, data} per active edge
  // ----------------------------------------------------------------
  logic [WORD_W+1:0] cur_r, st1_r, st2_r;
  logic [WORD_W:0] got_q[$];
  initial begin
    clk_enable_n_o = 1'b1;
    {cur_r, st1_r, st2_r, wdata_o} = '0;
  end
  // a released bus shows the inverse of its last value, not a held copy
  always @(posedge clk_i) begin
    if (!clk_enable_n_o) begin
      if (st2_r[WORD_W+1] && !st2_r[WORD_W]) begin
        got_q.push_back({data_oe_i, parity_pins_i, data_pins_i});
      end
      st1_r <= cur_r;
      st2_r <= st1_r;
      wdata_o <= (st1_r[WORD_W+1] && st1_r[WORD_W]) ? st1_r[WORD_W-1:0] : ~wdata_o;
    end else if (!(st2_r[WORD_W+1] && st2_r[WORD_W])) begin
      wdata_o <= ~wdata_o;
    end
  end
  // one pin cycle; lane enables always valid, order pin left to the bench
  task automatic beat(input logic stall, input logic adv, input logic rnw,
      input logic [2:0] sel, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] b,
      input logic x, input logic [WORD_W-1:0] wd);
    clk_enable_n_o <= stall;
    advance_or_load_o <= adv;
    read_not_write_o <= rnw;
    sel_o <= sel;
    addr_o <= a;
    byte_write_n_o <= b;
    cur_r <= {x & ~stall, ~rnw, wd};
    @(posedge clk_i);
  endtask
endmodule // sbp_ctl_model
`default_nettype wire

// ---- tb/sbp_sram_port_tb_top.sv ----
// self-checking bench: pin traffic against a queue model, plus wishbone
// assumes sbp_pkg and sbp_ctl_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module sbp_sram_port_tb_top
  import sbp_pkg::*;
;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic lin_n, oe_n, sleep_req, cen_n, rnw, advance_or_load, data_oe;
  logic [2:0] sel;
  logic [ADDR_W-1:0] addr, b_base, last_base;
  logic [LANES-1:0] be_n, par_o;
  logic [DATA_W-1:0] dat_o;
  logic [WORD_W-1:0] wdata;
  logic [WORD_W-1:0] mem [16];
  logic [WORD_W:0] exp_q[$];
  logic [2:0] dpat [3] = '{3'b101, 3'b011, 3'b000};
  logic b_on, b_wr, wblk, oe_exp, last_wr, full_be;
  int n_errors, num_checks, seed, b_cnt, i, j;

  sbp_sram_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .clk_enable_n_i(cen_n),
    .addr_i(addr), .read_not_write_i(rnw), .advance_or_load_i(advance_or_load),
    .chip_select1_n_i(sel[2]), .chip_select2_n_i(sel[1]), .chip_select_hi_i(sel[0]),
    .byte_write_n_i(be_n), .linear_order_n_i(lin_n), .output_enable_n_i(oe_n),
    .sleep_request_i(sleep_req), .data_pins_i(wdata[DATA_W-1:0]),
    .parity_pins_i(wdata[WORD_W-1:DATA_W]), .data_pins_o(dat_o), .parity_pins_o(par_o),
    .data_oe_o(data_oe));
  sbp_ctl_model i_ctl (.clk_i(clk_i), .data_pins_i(dat_o), .parity_pins_i(par_o),
    .data_oe_i(data_oe), .clk_enable_n_o(cen_n), .addr_o(addr), .read_not_write_o(rnw),
    .advance_or_load_o(advance_or_load), .sel_o(sel), .byte_write_n_o(be_n), .wdata_o(wdata));

  // ----------------------------------------------------------------
  // clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // cuts a hang well inside the cycle budget
  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [WORD_W:0] g, input logic [WORD_W:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [WORD_W-1:0] lanes(input logic [LANES-1:0] b);
    logic [WORD_W-1:0] m;
    m = '0;
    for (int k = 0; k < LANES; k++) begin
      if (!b[k]) begin
        m[8*k +: 8] = 8'hff;
        m[DATA_W+k] = 1'b1;
      end
    end
    return m;
  endfunction
  // reference model of one transfer beat
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] b,
      input logic [WORD_W-1:0] wd);
    if (b_wr && !wblk) begin
      mem[a[3:0]] = (mem[a[3:0]] & ~lanes(b)) | (wd & lanes(b));
    end else if (!b_wr) begin
      exp_q.push_back({oe_exp, mem[a[3:0]]});
    end
  endtask
  // a read right behind a write to the same block gets one idle cycle
  task automatic load(input logic rv, input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] wd;
    logic [LANES-1:0] b;
    wd = WORD_W'({$random(seed), $random(seed)});
    b = full_be ? '0 : LANES'($random(seed));
    if (last_wr && rv && a[3:2] == last_base[3:2]) desel(3'b000);
    b_on = 1'b1;
    b_cnt = 0;
    b_base = a;
    b_wr = !rv;
    last_wr = !rv;
    last_base = a;
    xfer(a, b, wd);
    i_ctl.beat(1'b0, 1'b0, rv, 3'b001, a, b, 1'b1, wd);
  endtask
  task automatic adv();
    logic [WORD_W-1:0] wd;
    logic [LANES-1:0] b;
    logic [1:0] lo;
    logic x;
    wd = WORD_W'({$random(seed), $random(seed)});
    b = full_be ? '0 : LANES'($random(seed));
    x = b_on && b_cnt < 3;
    if (x) begin
      b_cnt++;
      lo = lin_n ? (b_base[1:0] ^ 2'(b_cnt)) : (b_base[1:0] + 2'(b_cnt));
      xfer({b_base[ADDR_W-1:2], lo}, b, wd);
    end
    i_ctl.beat(1'b0, 1'b1, !b_wr, 3'b001, ADDR_W'($random(seed)), b, x, wd);
  endtask
  task automatic desel(input logic [2:0] s);
    b_on = 1'b0;
    i_ctl.beat(1'b0, 1'b0, 1'b1, s, ADDR_W'($random(seed)), '1, 1'b0, '0);
  endtask
  // suspended edge carrying a live-looking load on the other pins
  task automatic stall();
    ce_i <= 1'($random(seed));
    i_ctl.beat(1'b1, 1'b0, 1'($random(seed)), 3'b001, ADDR_W'($random(seed)),
      LANES'($random(seed)), 1'b0, '0);
    ce_i <= 1'b1;
  endtask
  task automatic drain();
    logic [WORD_W:0] g, e;
    while (exp_q.size() > 0 && i_ctl.got_q.size() > 0) begin
      g = i_ctl.got_q.pop_front();
      e = exp_q.pop_front();
      if (e[WORD_W]) check(g, e);
      else check((WORD_W+1)'(g[WORD_W]), '0);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, ce_i, wb_sel_i, oe_exp, full_be} = 8'hff;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {lin_n, oe_n, sleep_req, wblk, b_on, last_wr} = '0;
    seed = 32'hefdcf2a3;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 16; i += 4) begin
      load(1'b0, ADDR_W'(i));
      repeat (3) adv();
    end
    full_be = 1'b0;
    for (i = 0; i < 48; i++) begin
      if (i % 12 == 0) begin
        desel(3'b000);
        lin_n <= ~lin_n;
      end
      load(1'($random(seed)), ADDR_W'($random(seed) & 15));
      for (j = 0; j < 4; j++) begin
        if (($random(seed) & 3) == 0) stall();
        if (j < 3 || i % 3 == 0) adv();
      end
      if (i % 4 == 1) begin
        desel(dpat[i % 3]);
        adv();
      end
      drain();
    end
    repeat (3) desel(3'b101);
    #1 check((WORD_W+1)'(data_oe), '0);
    @(posedge clk_i); // back on the edge before driving again
    oe_n <= 1'b1;
    oe_exp = 1'b0;
    repeat (3) desel(3'b011);
    load(1'b1, 18'h4);
    repeat (3) adv();
    oe_n <= 1'b0;
    oe_exp = 1'b1;
    repeat (4) desel(3'b000);
    wb(1'b1, 4'h0, 32'h1, rd);
    wb(1'b0, 4'h0, 32'h0, rd);
    check((WORD_W+1)'(rd), (WORD_W+1)'(1 << CTRL_WBLK));
    wblk = 1'b1;
    load(1'b0, 18'h8);
    repeat (3) adv();
    repeat (4) desel(3'b000);
    wb(1'b1, 4'h0, 32'h0, rd);
    wblk = 1'b0;
    load(1'b1, 18'h8);
    repeat (3) adv();
    repeat (3) desel(3'b000);
    wb(1'b0, 4'h8, 32'h0, rd);
    check((WORD_W+1)'(rd), '0);
    sleep_req <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, 4'h4, 32'h0, rd);
    check((WORD_W+1)'({rd, data_oe}), (WORD_W+1)'(2));
    sleep_req <= 1'b0;
    repeat (4) @(posedge clk_i);
    load(1'b1, 18'hc);
    repeat (3) adv();
    repeat (4) desel(3'b000);
    drain();
    check((WORD_W+1)'(i_ctl.got_q.size()), (WORD_W+1)'(exp_q.size()));
    tally_and_finish();
  end
endmodule // sbp_sram_port_tb_top
`default_nettype wire
